//--- src/iec_pkg.sv
// shared constants for the incremental encoder counting channel
package iec_pkg;

  localparam int unsigned COUNT_W = 32;
  localparam int unsigned SCALE_W = 20;
  localparam int unsigned MULT_W = 10;
  localparam int unsigned LOOP_W = 20;
  localparam int unsigned PRESET_W = 4;
  localparam int unsigned AMOUNT_W = SCALE_W + MULT_W;
  localparam int unsigned ACC_W = 34;

  // encoder properties
  localparam logic ENC_PULSE_DIR = 1'h0;
  localparam logic ENC_QUADRATURE = 1'h1;
  localparam logic ENC_PROPS_RESET = ENC_QUADRATURE;

  // edge evaluation
  localparam logic [1:0] EDGE_X1 = 2'h0;
  localparam logic [1:0] EDGE_X2 = 2'h1;
  localparam logic [1:0] EDGE_X4 = 2'h2;
  localparam logic [1:0] EDGE_RESET = EDGE_X1;

  // counting direction
  localparam logic DIR_UP_A_LEADS = 1'h0;
  localparam logic DIR_DOWN_A_LEADS = 1'h1;
  localparam logic DIR_RESET = DIR_UP_A_LEADS;

  // display formats
  localparam logic [1:0] FMT_DECIMAL = 2'h0;
  localparam logic [1:0] FMT_ANGLE_FULL = 2'h1;
  localparam logic [1:0] FMT_ANGLE_HALF = 2'h2;
  localparam logic [1:0] FMT_RESET = FMT_DECIMAL;

  // power-down memory
  localparam logic PDM_OFF = 1'h0;
  localparam logic PDM_ON = 1'h1;
  localparam logic PDM_RESET = PDM_OFF;

  // preset mode selector value that allows a set command
  localparam logic [PRESET_W-1:0] PRESET_SET_ALLOWED = 4'h0;

  // scaling factor in units of 0.00001
  localparam logic [SCALE_W-1:0] SCALE_ONE = 20'h186A0;
  localparam logic [SCALE_W-1:0] SCALE_MIN = 20'h00001;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 20'hF423F;
  localparam logic [SCALE_W-1:0] SCALE_RESET = SCALE_ONE;

  // integer multiplier
  localparam logic [MULT_W-1:0] MULT_MIN = 10'h001;
  localparam logic [MULT_W-1:0] MULT_MAX = 10'h3E7;
  localparam logic [MULT_W-1:0] MULT_RESET = MULT_MIN;

  // round loop
  localparam logic [LOOP_W-1:0] LOOP_UNLIMITED = 20'h00000;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 20'hF423F;

  // angular display
  localparam logic signed [ACC_W-1:0] ANGLE_TURN = 34'h000005460;
  localparam logic signed [ACC_W-1:0] ANGLE_HALF_TURN = 34'h000002A30;
  localparam logic signed [ACC_W-1:0] MIN_PER_DEG = 34'h00000003C;
  localparam logic signed [ACC_W-1:0] DEG_WEIGHT = 34'h000000064;

  // cycles after reset before the pin pipeline holds real levels
  localparam logic [1:0] SYNC_FILL = 2'h3;
  localparam logic [1:0] SYNC_FILL_RESET = 2'h0;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h00000000;
  localparam logic [ACC_W-1:0] RESIDUE_RESET = 34'h000000000;

endpackage

//--- src/iec_step_if.sv
// decoded count events passed from the edge decoder to the counter
`timescale 1ns/100ps
interface iec_step_if;
  logic step;
  logic up;
  logic glitch;
  modport dec (output step, output up, output glitch);
  modport cnt (input step, input up, input glitch);
endinterface

//--- src/iec_edge_decoder.sv
// input synchroniser and edge decoder for encoder channels a and b
`timescale 1ns/100ps
module iec_edge_decoder (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_props_i,
  input wire logic [1:0] edge_eval_i,
  input wire logic count_dir_i,
  iec_step_if.dec step_if
);

  logic a_meta_reg;
  logic a_sync_reg;
  logic a_prev_reg;
  logic b_meta_reg;
  logic b_sync_reg;
  logic b_prev_reg;
  logic step_reg;
  logic up_reg;
  logic glitch_reg;
  logic step_next;
  logic up_next;
  logic glitch_next;
  logic a_rise;
  logic a_edge;
  logic b_edge;
  logic fwd;
  logic [1:0] fill_reg;
  logic [1:0] fill_next;
  logic armed;

  always_comb begin
    a_rise = a_sync_reg & ~a_prev_reg;
    a_edge = a_sync_reg ^ a_prev_reg;
    b_edge = b_sync_reg ^ b_prev_reg;
    step_next = 1'b0;
    glitch_next = 1'b0;
    fwd = 1'b1;
    // a pin already high at reset release must not look like an edge
    armed = (fill_reg == iec_pkg::SYNC_FILL);
    fill_next = armed ? fill_reg : fill_reg + 2'h1;
    if (enc_props_i == iec_pkg::ENC_PULSE_DIR) begin
      // b is a static level here, so x4 falls back to both a edges
      fwd = ~b_sync_reg;
      if (edge_eval_i == iec_pkg::EDGE_X1) begin
        step_next = a_rise;
      end else begin
        step_next = a_edge;
      end
    end else if (a_edge && b_edge) begin
      glitch_next = 1'b1;
    end else begin
      // a leads b when a differs from b after an a edge
      fwd = a_edge ? (a_sync_reg != b_sync_reg) : (b_sync_reg == a_sync_reg);
      case (edge_eval_i)
        iec_pkg::EDGE_X1: step_next = a_rise;
        iec_pkg::EDGE_X2: step_next = a_edge;
        iec_pkg::EDGE_X4: step_next = a_edge | b_edge;
        default: step_next = a_rise;
      endcase
    end
    if (!armed) begin
      step_next = 1'b0;
      glitch_next = 1'b0;
    end
    up_next = (count_dir_i == iec_pkg::DIR_UP_A_LEADS) ? fwd : ~fwd;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_meta_reg <= 1'b0;
      a_sync_reg <= 1'b0;
      a_prev_reg <= 1'b0;
      b_meta_reg <= 1'b0;
      b_sync_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      step_reg <= 1'b0;
      up_reg <= 1'b0;
      glitch_reg <= 1'b0;
      fill_reg <= iec_pkg::SYNC_FILL_RESET;
    end else begin
      a_meta_reg <= enc_a_i;
      a_sync_reg <= a_meta_reg;
      a_prev_reg <= a_sync_reg;
      b_meta_reg <= enc_b_i;
      b_sync_reg <= b_meta_reg;
      b_prev_reg <= b_sync_reg;
      step_reg <= step_next;
      up_reg <= up_next;
      glitch_reg <= glitch_next;
      fill_reg <= fill_next;
    end
  end

  assign step_if.step = step_reg;
  assign step_if.up = up_reg;
  assign step_if.glitch = glitch_reg;

endmodule // iec_edge_decoder

//--- src/iec_counter_top.sv
// incremental encoder counting channel: scaling, set, round loop, display, retention
`timescale 1ns/100ps
// Contract
// - properties 0: a pulses, b gives direction
// - properties 1: decode a and b as quadrature
// - edge evaluation 0: rising a edges only
// - edge evaluation 1: both a edges
// - edge evaluation 2: every a and b edge in quadrature, both a edges with properties 0
// - direction 0: count up when a leads
// - direction 1: count down when a leads
// - scale each edge by 0.00001 to 9.99999
// - add each edge multiplier times, 1 to 999
// - set command loads set value if selector 0
// - round loop 0 counts without wrap
// - round loop n cycles count over 0 to n
// - display decimal, 0..359.59 or -180.00..179.59
// - memory off: restart from zero at power-up
// - memory on: resume from last count
module iec_counter_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_props_i,
  input wire logic [1:0] edge_eval_i,
  input wire logic count_dir_i,
  input wire logic [iec_pkg::SCALE_W-1:0] scale_factor_i,
  input wire logic [iec_pkg::MULT_W-1:0] multiplier_i,
  input wire logic [iec_pkg::COUNT_W-1:0] set_value_i,
  input wire logic set_cmd_i,
  input wire logic [iec_pkg::PRESET_W-1:0] preset_mode_selector_i,
  input wire logic [iec_pkg::LOOP_W-1:0] round_loop_i,
  input wire logic [1:0] display_format_i,
  input wire logic power_down_memory_i,
  input wire logic [iec_pkg::COUNT_W-1:0] retained_count_i,
  output logic [iec_pkg::COUNT_W-1:0] count_o,
  output logic [iec_pkg::COUNT_W-1:0] display_o,
  output logic count_valid_o,
  output logic step_o,
  output logic up_o,
  output logic glitch_o,
  output logic wrap_o,
  output logic set_done_o,
  output logic config_error_o
);

  // restore lasts one cycle, so the stored count is read once
  typedef enum logic {
    IEC_RESTORE,
    IEC_RUN
  } iec_run_state_t;

  // decoded events arrive one cycle behind the sync stages
  iec_step_if step_if ();

  iec_edge_decoder u_decoder (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .enc_a_i(enc_a_i),
    .enc_b_i(enc_b_i),
    .enc_props_i(enc_props_i),
    .edge_eval_i(edge_eval_i),
    .count_dir_i(count_dir_i),
    .step_if(step_if)
  );

  // wraps a value into 0..n; n = 0 means no wrap, plain 32-bit count
  function automatic logic signed [iec_pkg::ACC_W-1:0] wrap_loop(
    input logic signed [iec_pkg::ACC_W-1:0] value,
    input logic [iec_pkg::LOOP_W-1:0] loop_len
  );
    logic signed [iec_pkg::ACC_W-1:0] modulus;
    logic signed [iec_pkg::ACC_W-1:0] rest;
    // modulus is n + 1 so that n itself is reachable
    modulus = $signed({{(iec_pkg::ACC_W-iec_pkg::LOOP_W){1'b0}}, loop_len}) + 34'sh000000001;
    rest = value % modulus;
    if (rest < 0) begin
      rest = rest + modulus;
    end
    if (loop_len == iec_pkg::LOOP_UNLIMITED) begin
      wrap_loop = value;
    end else begin
      wrap_loop = rest;
    end
  endfunction

  // count read as arc minutes, shown as degrees * 100 + minutes
  function automatic logic [iec_pkg::COUNT_W-1:0] format_count(
    input logic [iec_pkg::COUNT_W-1:0] count,
    input logic [1:0] fmt
  );
    logic signed [iec_pkg::ACC_W-1:0] angle;
    logic signed [iec_pkg::ACC_W-1:0] signed_angle;
    logic signed [iec_pkg::ACC_W-1:0] mag;
    logic signed [iec_pkg::ACC_W-1:0] shown;
    angle = $signed({{(iec_pkg::ACC_W-iec_pkg::COUNT_W){count[iec_pkg::COUNT_W-1]}}, count})
      % iec_pkg::ANGLE_TURN;
    if (angle < 0) begin
      angle = angle + iec_pkg::ANGLE_TURN;
    end
    signed_angle = (angle >= iec_pkg::ANGLE_HALF_TURN) ? angle - iec_pkg::ANGLE_TURN : angle;
    mag = (signed_angle < 0) ? -signed_angle : signed_angle;
    shown = (mag / iec_pkg::MIN_PER_DEG) * iec_pkg::DEG_WEIGHT + (mag % iec_pkg::MIN_PER_DEG);
    case (fmt)
      iec_pkg::FMT_DECIMAL: format_count = count;
      iec_pkg::FMT_ANGLE_FULL: begin
        shown = (angle / iec_pkg::MIN_PER_DEG) * iec_pkg::DEG_WEIGHT + (angle % iec_pkg::MIN_PER_DEG);
        format_count = shown[iec_pkg::COUNT_W-1:0];
      end
      // 10800 minutes and above read as a negative angle
      iec_pkg::FMT_ANGLE_HALF: begin
        if (signed_angle < 0) begin
          shown = -shown;
        end
        format_count = shown[iec_pkg::COUNT_W-1:0];
      end
      default: format_count = count;
    endcase
  endfunction

  // configuration clamping
  logic [iec_pkg::SCALE_W-1:0] scale_eff;
  logic [iec_pkg::MULT_W-1:0] mult_eff;
  logic [iec_pkg::LOOP_W-1:0] loop_eff;
  logic config_bad;
  logic edge_bad;
  logic format_bad;

  // out-of-range scale, multiplier and loop are clamped; every bad setting, edge and format included, is flagged
  always_comb begin
    config_bad = 1'b0;
    scale_eff = scale_factor_i;
    mult_eff = multiplier_i;
    loop_eff = round_loop_i;
    if (scale_factor_i < iec_pkg::SCALE_MIN) begin
      scale_eff = iec_pkg::SCALE_MIN;
      config_bad = 1'b1;
    end else if (scale_factor_i > iec_pkg::SCALE_MAX) begin
      scale_eff = iec_pkg::SCALE_MAX;
      config_bad = 1'b1;
    end
    if (multiplier_i < iec_pkg::MULT_MIN) begin
      mult_eff = iec_pkg::MULT_MIN;
      config_bad = 1'b1;
    end else if (multiplier_i > iec_pkg::MULT_MAX) begin
      mult_eff = iec_pkg::MULT_MAX;
      config_bad = 1'b1;
    end
    if (round_loop_i > iec_pkg::LOOP_MAX) begin
      loop_eff = iec_pkg::LOOP_MAX;
      config_bad = 1'b1;
    end
    edge_bad = edge_eval_i > iec_pkg::EDGE_X4;
    format_bad = display_format_i > iec_pkg::FMT_ANGLE_HALF;
    if (edge_bad || format_bad) begin
      config_bad = 1'b1;
    end
  end

  // counter state
  iec_run_state_t state_reg;
  iec_run_state_t state_next;
  logic [iec_pkg::COUNT_W-1:0] count_reg;
  logic [iec_pkg::COUNT_W-1:0] count_next;
  logic [iec_pkg::ACC_W-1:0] residue_reg;
  logic [iec_pkg::ACC_W-1:0] residue_next;
  logic [iec_pkg::COUNT_W-1:0] display_reg;
  logic [iec_pkg::COUNT_W-1:0] display_next;
  logic valid_reg;
  logic valid_next;
  logic step_reg;
  logic up_reg;
  logic glitch_reg;
  logic wrap_reg;
  logic wrap_next;
  logic set_done_reg;
  logic set_done_next;
  logic config_error_reg;

  logic [iec_pkg::AMOUNT_W-1:0] amount;
  logic signed [iec_pkg::ACC_W-1:0] total;
  logic signed [iec_pkg::ACC_W-1:0] whole;
  logic signed [iec_pkg::ACC_W-1:0] sum;
  logic signed [iec_pkg::ACC_W-1:0] wrapped;
  logic signed [iec_pkg::ACC_W-1:0] load_value;
  logic set_ok;
  logic signed [iec_pkg::ACC_W-1:0] count_ext;
  logic signed [iec_pkg::ACC_W-1:0] set_ext;
  logic signed [iec_pkg::ACC_W-1:0] kept_ext;
  logic step_next;
  logic up_next;
  logic glitch_next;
  logic config_error_next;

  // step arithmetic, shared by every state
  always_comb begin
    count_ext = $signed({{(iec_pkg::ACC_W-iec_pkg::COUNT_W){count_reg[iec_pkg::COUNT_W-1]}}, count_reg});
    set_ext = $signed({{(iec_pkg::ACC_W-iec_pkg::COUNT_W){set_value_i[iec_pkg::COUNT_W-1]}}, set_value_i});
    kept_ext = $signed({{(iec_pkg::ACC_W-iec_pkg::COUNT_W){retained_count_i[iec_pkg::COUNT_W-1]}}, retained_count_i});
    // fractional remainder is carried, so scaled edges never lose counts
    amount = iec_pkg::AMOUNT_W'(mult_eff * scale_eff);
    if (step_if.up) begin
      total = $signed(residue_reg) + $signed({4'h0, amount});
    end else begin
      total = $signed(residue_reg) - $signed({4'h0, amount});
    end
    // division truncates toward zero, so up and down steps stay symmetric
    whole = total / $signed({14'h0000, iec_pkg::SCALE_ONE});
    sum = count_ext + whole;
    wrapped = wrap_loop(sum, loop_eff);
    set_ok = set_cmd_i && (preset_mode_selector_i == iec_pkg::PRESET_SET_ALLOWED);
  end

  // status pulses follow the decoder one cycle later, in step with the count
  always_comb begin
    step_next = step_if.step;
    up_next = step_if.up;
    glitch_next = step_if.glitch;
    config_error_next = config_bad;
  end

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    residue_next = residue_reg;
    valid_next = valid_reg;
    wrap_next = 1'b0;
    set_done_next = 1'b0;
    load_value = wrap_loop(set_ext, loop_eff);
    case (state_reg)
      IEC_RESTORE: begin
        if (power_down_memory_i == iec_pkg::PDM_ON) begin
          // the store is outside the block; its word is only read here
          load_value = wrap_loop(kept_ext, loop_eff);
          count_next = load_value[iec_pkg::COUNT_W-1:0];
        end else begin
          count_next = iec_pkg::COUNT_RESET;
        end
        residue_next = iec_pkg::RESIDUE_RESET;
        valid_next = 1'b1;
        state_next = IEC_RUN;
      end
      IEC_RUN: begin
        // a set command outranks an edge in the same cycle
        if (set_ok) begin
          count_next = load_value[iec_pkg::COUNT_W-1:0];
          residue_next = iec_pkg::RESIDUE_RESET;
          set_done_next = 1'b1;
        end else if (step_if.step) begin
          count_next = wrapped[iec_pkg::COUNT_W-1:0];
          residue_next = total - whole * $signed({14'h0000, iec_pkg::SCALE_ONE});
          wrap_next = (loop_eff != iec_pkg::LOOP_UNLIMITED) && (wrapped != sum);
        end
      end
      default: state_next = IEC_RESTORE;
    endcase
    // display follows count_next so both change on one edge
    display_next = format_count(count_next, display_format_i);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= IEC_RESTORE;
      count_reg <= iec_pkg::COUNT_RESET;
      residue_reg <= iec_pkg::RESIDUE_RESET;
      display_reg <= iec_pkg::COUNT_RESET;
      valid_reg <= 1'b0;
      wrap_reg <= 1'b0;
      set_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      residue_reg <= residue_next;
      display_reg <= display_next;
      valid_reg <= valid_next;
      wrap_reg <= wrap_next;
      set_done_reg <= set_done_next;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_reg <= 1'b0;
      up_reg <= 1'b0;
      glitch_reg <= 1'b0;
      config_error_reg <= 1'b0;
    end else begin
      step_reg <= step_next;
      up_reg <= up_next;
      glitch_reg <= glitch_next;
      config_error_reg <= config_error_next;
    end
  end

  assign count_o = count_reg;
  assign display_o = display_reg;
  assign count_valid_o = valid_reg;
  assign step_o = step_reg;
  assign up_o = up_reg;
  assign glitch_o = glitch_reg;
  assign wrap_o = wrap_reg;
  assign set_done_o = set_done_reg;
  assign config_error_o = config_error_reg;

endmodule // iec_counter_top

//--- dv/iec_counter_top_props.sv
// concurrent checks on the ports of the encoder counting channel
`timescale 1ns/100ps
module iec_counter_top_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [19:0] scale_factor_i,
  input wire logic [9:0] multiplier_i,
  input wire logic [31:0] set_value_i,
  input wire logic set_cmd_i,
  input wire logic [3:0] preset_mode_selector_i,
  input wire logic [19:0] round_loop_i,
  input wire logic [1:0] display_format_i,
  input wire logic power_down_memory_i,
  input wire logic [31:0] retained_count_i,
  input wire logic [31:0] count_o,
  input wire logic [31:0] display_o,
  input wire logic count_valid_o,
  input wire logic step_o,
  input wire logic up_o,
  input wire logic glitch_o,
  input wire logic wrap_o,
  input wire logic set_done_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SET_LOAD: assert property (count_valid_o && set_cmd_i && preset_mode_selector_i == 4'h0
    && round_loop_i == 20'h00000 |=> set_done_o && count_o == $past(set_value_i)) else $error("set value not loaded");
  AST_SET_REFUSE: assert property (set_cmd_i && preset_mode_selector_i != 4'h0 |=> !set_done_o)
    else $error("set accepted with nonzero selector");
  AST_GLITCH_HOLD: assert property (glitch_o && !set_done_o |-> !step_o && $stable(count_o))
    else $error("count moved on a double change");
  // residue is zero here only because every scale change is followed by a set
  AST_UNIT_STEP: assert property (step_o && !set_done_o && multiplier_i == 10'h001
    && scale_factor_i == 20'h186A0 && round_loop_i == 20'h00000
    |-> count_o == $past(count_o) + (up_o ? 32'h00000001 : 32'hFFFFFFFF)) else $error("unit step wrong");
  AST_LOOP_RANGE: assert property ((step_o || set_done_o) && round_loop_i != 20'h00000
    && $stable(round_loop_i) |-> count_o <= {12'h000, round_loop_i}) else $error("count outside loop range");
  AST_WRAP_CAUSE: assert property (wrap_o |-> round_loop_i != 20'h00000 && (step_o || set_done_o))
    else $error("wrap without loop or update");
  AST_RESTORE_ZERO: assert property ($rose(count_valid_o) && !power_down_memory_i
    |-> count_o == 32'h00000000) else $error("restart not from zero");
  AST_RESTORE_KEEP: assert property ($rose(count_valid_o) && power_down_memory_i
    && round_loop_i == 20'h00000 |-> count_o == retained_count_i) else $error("retained count lost");
  AST_DISP_DEC: assert property ((step_o || set_done_o) && display_format_i == 2'h0
    && $stable(display_format_i) |-> display_o == count_o) else $error("decimal display differs");
endmodule // iec_counter_top_props
bind iec_counter_top iec_counter_top_props iec_counter_top_props_i (.clk_sys_i, .rst_n_i, .scale_factor_i,
  .multiplier_i, .set_value_i, .set_cmd_i, .preset_mode_selector_i, .round_loop_i, .display_format_i,
  .power_down_memory_i, .retained_count_i, .count_o, .display_o, .count_valid_o, .step_o, .up_o,
  .glitch_o, .wrap_o, .set_done_o);

//--- dv/iec_enc_model.sv
// behavioural incremental encoder driving channels a and b
`timescale 1ns/100ps
module iec_enc_model (
  input wire logic clk_i,
  output logic a_o,
  output logic b_o
);
  initial begin
    a_o = 1'h0;
    b_o = 1'h0;
  end
  // four clocks per level, well above the decoder's one-clock spacing
  task automatic hold();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic quad(input int n, input logic fwd);
    for (int k = 0; k < n; k++) begin
      if (fwd) begin
        {a_o, b_o} = {!b_o, a_o};
      end else begin
        {a_o, b_o} = {b_o, !a_o};
      end
      hold();
    end
  endtask
  task automatic pulse(input int n, input logic fwd);
    b_o = !fwd;
    hold();
    for (int k = 0; k < n; k++) begin
      a_o = 1'h1;
      hold();
      a_o = 1'h0;
      hold();
    end
  endtask
  // fault: both channels flip at once, only on request
  task automatic both();
    {a_o, b_o} = ~{a_o, b_o};
    hold();
  endtask
endmodule // iec_enc_model

//--- dv/iec_counter_top_test.sv
// self-checking bench for the incremental encoder counting channel
`timescale 1ns/100ps
module iec_counter_top_test;
  typedef struct packed {
    logic props;
    logic [1:0] edge_sel;
    logic dir;
    logic fwd;
    logic [9:0] mult;
    logic [19:0] scale;
    logic [31:0] exp;
  } iec_row_t;
  iec_row_t rows [0:14];
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic enc_a_i, enc_b_i;
  logic enc_props_i = 1'h1;
  logic [1:0] edge_eval_i = 2'h0;
  logic count_dir_i = 1'h0;
  logic [19:0] scale_factor_i = 20'h186A0;
  logic [9:0] multiplier_i = 10'h001;
  logic [31:0] set_value_i = 32'h0;
  logic set_cmd_i = 1'h0;
  logic [3:0] preset_mode_selector_i = 4'h0;
  logic [19:0] round_loop_i = 20'h0;
  logic [1:0] display_format_i = 2'h0;
  logic power_down_memory_i = 1'h0;
  logic [31:0] retained_count_i = 32'h0;
  logic [31:0] count_o, display_o;
  logic count_valid_o, step_o, up_o, glitch_o, wrap_o, set_done_o, config_error_o;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  iec_counter_top iec_counter_top_i (.clk_sys_i, .rst_n_i, .enc_a_i, .enc_b_i, .enc_props_i, .edge_eval_i,
    .count_dir_i, .scale_factor_i, .multiplier_i, .set_value_i, .set_cmd_i, .preset_mode_selector_i,
    .round_loop_i, .display_format_i, .power_down_memory_i, .retained_count_i, .count_o, .display_o,
    .count_valid_o, .step_o, .up_o, .glitch_o, .wrap_o, .set_done_o, .config_error_o);
  iec_enc_model iec_enc_model_i (.clk_i(clk_sys_i), .a_o(enc_a_i), .b_o(enc_b_i));

  always #50 clk_sys_i = ~clk_sys_i;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // a set also clears the scaling residue, so each case starts clean
  task automatic do_set(input logic [31:0] v, input logic done);
    set_value_i = v;
    set_cmd_i = 1'h1;
    tick(1);
    set_cmd_i = 1'h0;
    check({31'h0, set_done_o}, {31'h0, done});
    tick(2);
  endtask

  initial begin
    rows = '{'{1'h1, 2'h0, 1'h0, 1'h1, 10'h001, 20'h186A0, 32'h2},
      '{1'h1, 2'h1, 1'h0, 1'h1, 10'h001, 20'h186A0, 32'h4},
      '{1'h1, 2'h2, 1'h0, 1'h1, 10'h001, 20'h186A0, 32'h8},
      '{1'h1, 2'h2, 1'h0, 1'h0, 10'h001, 20'h186A0, 32'hFFFFFFF8},
      '{1'h1, 2'h2, 1'h1, 1'h1, 10'h001, 20'h186A0, 32'hFFFFFFF8},
      '{1'h1, 2'h0, 1'h1, 1'h0, 10'h001, 20'h186A0, 32'h2},
      '{1'h0, 2'h0, 1'h0, 1'h1, 10'h001, 20'h186A0, 32'h2},
      '{1'h0, 2'h1, 1'h0, 1'h1, 10'h001, 20'h186A0, 32'h4},
      '{1'h0, 2'h2, 1'h0, 1'h1, 10'h001, 20'h186A0, 32'h4},
      '{1'h0, 2'h1, 1'h0, 1'h0, 10'h001, 20'h186A0, 32'hFFFFFFFC},
      '{1'h0, 2'h0, 1'h1, 1'h1, 10'h001, 20'h186A0, 32'hFFFFFFFE},
      '{1'h1, 2'h0, 1'h0, 1'h1, 10'h3E7, 20'h186A0, 32'h7CE},
      '{1'h1, 2'h2, 1'h0, 1'h1, 10'h001, 20'h0C350, 32'h4},
      '{1'h1, 2'h2, 1'h0, 1'h1, 10'h003, 20'hF423F, 32'hEF},
      '{1'h1, 2'h0, 1'h0, 1'h1, 10'h3E7, 20'h00001, 32'h0}};
    tick(20);
    rst_n_i = 1'h1;
    tick(2);
    check(count_o, 32'h0);
    check({31'h0, count_valid_o}, 32'h1);
    for (int r = 0; r < 15; r++) begin
      enc_props_i = rows[r].props;
      edge_eval_i = rows[r].edge_sel;
      count_dir_i = rows[r].dir;
      multiplier_i = rows[r].mult;
      scale_factor_i = rows[r].scale;
      tick(2);
      do_set(32'h0, 1'h1);
      if (rows[r].props) begin
        iec_enc_model_i.quad(8, rows[r].fwd);
      end else begin
        iec_enc_model_i.pulse(2, rows[r].fwd);
      end
      tick(6);
      check(count_o, rows[r].exp);
      check(display_o, rows[r].exp);
    end
    enc_props_i = 1'h1;
    edge_eval_i = 2'h2;
    count_dir_i = 1'h0;
    multiplier_i = 10'h001;
    scale_factor_i = 20'h186A0;
    round_loop_i = 20'h00009;
    tick(2);
    do_set(32'h8, 1'h1);
    iec_enc_model_i.quad(4, 1'h1);
    tick(6);
    check(count_o, 32'h2);
    do_set(32'h0, 1'h1);
    iec_enc_model_i.quad(1, 1'h0);
    tick(6);
    check(count_o, 32'h9);
    round_loop_i = 20'h0;
    do_set(32'h5, 1'h1);
    preset_mode_selector_i = 4'h3;
    do_set(32'h4D, 1'h0);
    check(count_o, 32'h5);
    preset_mode_selector_i = 4'h0;
    iec_enc_model_i.both();
    tick(6);
    check(count_o, 32'h5);
    multiplier_i = 10'h000;
    tick(2);
    check({31'h0, config_error_o}, 32'h1);
    do_set(32'h0, 1'h1);
    iec_enc_model_i.quad(4, 1'h1);
    tick(6);
    check(count_o, 32'h4);
    multiplier_i = 10'h001;
    tick(2);
    check({31'h0, config_error_o}, 32'h0);
    display_format_i = 2'h1;
    do_set(32'h2EE, 1'h1);
    check(display_o, 32'h4CE);
    display_format_i = 2'h2;
    do_set(32'h2EE0, 1'h1);
    check(display_o, 32'hFFFFC180);
    display_format_i = 2'h0;
    power_down_memory_i = 1'h1;
    retained_count_i = 32'h1234;
    rst_n_i = 1'h0;
    tick(3);
    check(count_o, 32'h0);
    rst_n_i = 1'h1;
    tick(2);
    check(count_o, 32'h1234);
    tick(6);
    check(count_o, 32'h1234);
    end_sim();
  end
endmodule // iec_counter_top_test
